// *** logic/ira_regs.svh ***
// Constants of the serial register access front end
`ifndef IRA_REGS_SVH
`define IRA_REGS_SVH
// ****************************************
// Address byte
// ****************************************
`define IRA_ADDR_HI 4'h9
`define IRA_BCAST_ADDR 7'h47
`define IRA_GCALL_BYTE 8'h00
`define IRA_SWRST_BYTE 8'h06
`define IRA_STRAP_GND 3'h0
`define IRA_STRAP_VDD 3'h1
`define IRA_STRAP_SDA 3'h2
`define IRA_STRAP_SCL 3'h3
// ****************************************
// Command codes (register selectors)
// ****************************************
`define IRA_CMD_DEVICE_STATUS 8'hD0
`define IRA_CMD_GENERAL_SETTINGS 8'hD1
`define IRA_CMD_ACTION_TRIGGERS 8'hD3
`define IRA_CMD_OUTPUT_CODE 8'h21
`define IRA_CMD_UPPER_LIMIT_CODE 8'h25
`define IRA_CMD_LOWER_LIMIT_CODE 8'h26
`define IRA_CMD_POWER_OPERATION_COMMAND 8'h01
`define IRA_CMD_BUS_FAULT_FLAGS 8'h78
`define IRA_CMD_PROTOCOL_REVISION 8'h98
// ****************************************
// Framing counts
// ****************************************
`define IRA_BIT_LAST 4'h7
`define IRA_BIT_ACK 4'h8
`define IRA_BYTE_ADDR 3'h0
`define IRA_BYTE_CMD 3'h1
`define IRA_BYTE_UPPER 3'h2
`define IRA_BYTE_LOWER 3'h3
`define IRA_UPDATE_RISES 6'h24
`define IRA_RISES_MAX 6'h3F
`endif

// *** logic/ira_pkg.sv ***
// Types and decode helpers of the serial register access front end
`include "ira_regs.svh"
package ira_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT} ira_state_e;

    function automatic logic ira_cmd_ok(input logic [7:0] c);
        case (c)
            `IRA_CMD_DEVICE_STATUS, `IRA_CMD_GENERAL_SETTINGS, `IRA_CMD_ACTION_TRIGGERS,
            `IRA_CMD_OUTPUT_CODE, `IRA_CMD_UPPER_LIMIT_CODE, `IRA_CMD_LOWER_LIMIT_CODE,
            `IRA_CMD_POWER_OPERATION_COMMAND, `IRA_CMD_BUS_FAULT_FLAGS,
            `IRA_CMD_PROTOCOL_REVISION: ira_cmd_ok = 1'b1;
            default: ira_cmd_ok = 1'b0;
        endcase
    endfunction : ira_cmd_ok
endpackage : ira_pkg

// *** logic/ira_pair_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module ira_pair_buf import ira_pkg::*; #(
    parameter int W = 24
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic head_v;
        logic tail_v;
    } ira_buf_s;

    ira_buf_s buf_reg;
    ira_buf_s buf_next;

    always_comb begin
        buf_next = buf_reg;
        if (buf_reg.head_v && out_ready) begin
            buf_next.head = buf_reg.tail;
            buf_next.head_v = buf_reg.tail_v;
            buf_next.tail_v = 1'b0;
        end
        if (in_valid && !buf_reg.tail_v) begin
            if (!buf_next.head_v) begin
                buf_next.head = in_data;
                buf_next.head_v = 1'b1;
            end else begin
                buf_next.tail = in_data;
                buf_next.tail_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            buf_reg <= '0;
        end else begin
            buf_reg <= buf_next;
        end
    end

    assign in_ready = !buf_reg.tail_v;
    assign out_valid = buf_reg.head_v;
    assign out_data = buf_reg.head;

    no_drop_a: assert property (@(posedge clock) disable iff (rst)
        buf_reg.tail_v && !out_ready |=> buf_reg.tail_v && buf_reg.head_v)
        else $error("buffered word lost under stall");
endmodule : ira_pair_buf

// *** logic/ira_frontend.sv ***
// Serial target front end: address match, command decode, register write and read
`timescale 1ns/100ps
`include "ira_regs.svh"

module ira_frontend import ira_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_strap_pin,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [7:0] wr_addr,
    output logic [15:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [15:0] rd_data,
    output logic soft_reset
);
    typedef struct packed {
        ira_state_e state;
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic strap_s1;
        logic strap_s2;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic [2:0] byte_idx;
        logic [6:0] adr;
        logic rw;
        logic gcall;
        logic cmd_valid;
        logic [7:0] cmd;
        logic [7:0] last_addr;
        logic [7:0] upper;
        logic st_lo;
        logic st_hi;
        logic st_nsda;
        logic st_nscl;
        logic [2:0] strap_code;
        logic host_ack;
        logic sda_oe;
        logic [7:0] rd_addr;
        logic swrst;
        logic push;
        logic [5:0] rises;
    } ira_fe_s;

    ira_fe_s fe_reg;
    ira_fe_s fe_next;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic buf_in_ready;
    logic [2:0] strap_now;
    logic [23:0] buf_out;

    // ****************************************
    // Bus events
    // ****************************************
    assign scl_rise = fe_reg.scl_s2 && !fe_reg.scl_p;
    assign scl_fall = !fe_reg.scl_s2 && fe_reg.scl_p;
    assign start_cond = fe_reg.scl_s2 && fe_reg.scl_p && fe_reg.sda_p && !fe_reg.sda_s2;
    assign stop_cond = fe_reg.scl_s2 && fe_reg.scl_p && !fe_reg.sda_p && fe_reg.sda_s2;

    // Strap decode: steady low, steady high, follows data, follows clock
    always_comb begin
        if (!fe_reg.st_hi) begin
            strap_now = `IRA_STRAP_GND;
        end else if (!fe_reg.st_lo) begin
            strap_now = `IRA_STRAP_VDD;
        end else if (!fe_reg.st_nsda) begin
            strap_now = `IRA_STRAP_SDA;
        end else begin
            strap_now = `IRA_STRAP_SCL;
        end
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    always_comb begin
        fe_next = fe_reg;
        fe_next.scl_s1 = scl_in;
        fe_next.scl_s2 = fe_reg.scl_s1;
        fe_next.scl_p = fe_reg.scl_s2;
        fe_next.sda_s1 = sda_in;
        fe_next.sda_s2 = fe_reg.sda_s1;
        fe_next.sda_p = fe_reg.sda_s2;
        fe_next.strap_s1 = address_strap_pin;
        fe_next.strap_s2 = fe_reg.strap_s1;
        fe_next.swrst = 1'b0;
        fe_next.push = 1'b0;
        if (scl_rise && fe_reg.state != ST_IDLE && fe_reg.rises != `IRA_RISES_MAX) begin
            fe_next.rises = fe_reg.rises + 6'h01;
        end
        // Strap is watched on both clock edges of the address byte
        if ((scl_rise || scl_fall) && fe_reg.state == ST_RX
            && fe_reg.byte_idx == `IRA_BYTE_ADDR) begin
            if (fe_reg.strap_s2) begin
                fe_next.st_hi = 1'b1;
            end else begin
                fe_next.st_lo = 1'b1;
            end
            if (fe_reg.strap_s2 != fe_reg.sda_s2) begin
                fe_next.st_nsda = 1'b1;
            end
            if (fe_reg.strap_s2 != fe_reg.scl_s2) begin
                fe_next.st_nscl = 1'b1;
            end
        end
        if (stop_cond) begin
            fe_next.state = ST_IDLE;
            fe_next.sda_oe = 1'b0;
            fe_next.cmd_valid = 1'b0;
        end else if (start_cond) begin
            fe_next.state = ST_RX;
            fe_next.sda_oe = 1'b0;
            fe_next.bit_cnt = 4'h0;
            fe_next.byte_idx = `IRA_BYTE_ADDR;
            fe_next.gcall = 1'b0;
            fe_next.rises = 6'h00;
            fe_next.st_lo = 1'b0;
            fe_next.st_hi = 1'b0;
            fe_next.st_nsda = 1'b0;
            fe_next.st_nscl = 1'b0;
        end else begin
            case (fe_reg.state)
                ST_RX: begin
                    if (scl_rise && fe_reg.bit_cnt != `IRA_BIT_ACK) begin
                        fe_next.shift = {fe_reg.shift[6:0], fe_reg.sda_s2};
                        fe_next.bit_cnt = fe_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && fe_reg.bit_cnt == `IRA_BIT_ACK) begin
                        fe_next.sda_oe = 1'b0;
                        case (fe_reg.byte_idx)
                            `IRA_BYTE_ADDR: begin
                                fe_next.adr = fe_reg.shift[7:1];
                                fe_next.rw = fe_reg.shift[0];
                                fe_next.strap_code = strap_now;
                                if (fe_reg.shift[7:1] == {`IRA_ADDR_HI, strap_now}) begin
                                    fe_next.sda_oe = 1'b1;
                                end else if (fe_reg.shift[7:1] == `IRA_BCAST_ADDR
                                    && !fe_reg.shift[0]) begin
                                    fe_next.sda_oe = 1'b1;
                                end else if (fe_reg.shift == `IRA_GCALL_BYTE) begin
                                    fe_next.sda_oe = 1'b1;
                                    fe_next.gcall = 1'b1;
                                end
                                if (fe_reg.shift[0]) begin
                                    fe_next.rd_addr = fe_reg.cmd_valid ? fe_reg.cmd
                                        : fe_reg.last_addr;
                                end
                            end
                            `IRA_BYTE_CMD: begin
                                if (fe_reg.gcall) begin
                                    fe_next.sda_oe = (fe_reg.shift == `IRA_SWRST_BYTE);
                                end else if (ira_cmd_ok(fe_reg.shift)) begin
                                    fe_next.sda_oe = 1'b1;
                                    fe_next.cmd = fe_reg.shift;
                                    fe_next.cmd_valid = 1'b1;
                                end
                            end
                            `IRA_BYTE_UPPER: begin
                                fe_next.sda_oe = !fe_reg.gcall;
                                fe_next.upper = fe_reg.shift;
                            end
                            `IRA_BYTE_LOWER: begin
                                // Full buffer refuses the word with a not-acknowledge
                                fe_next.sda_oe = !fe_reg.gcall && buf_in_ready;
                            end
                            default: fe_next.sda_oe = 1'b0;
                        endcase
                        fe_next.state = fe_next.sda_oe ? ST_RX_ACK : ST_IDLE;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_rise && fe_reg.gcall && fe_reg.byte_idx == `IRA_BYTE_CMD) begin
                        fe_next.swrst = 1'b1;
                    end
                    if (scl_fall) begin
                        fe_next.sda_oe = 1'b0;
                        fe_next.bit_cnt = 4'h0;
                        if (fe_reg.byte_idx == `IRA_BYTE_LOWER) begin
                            fe_next.push = 1'b1;
                            fe_next.last_addr = fe_reg.cmd;
                            fe_next.state = ST_WAIT;
                        end else if (fe_reg.byte_idx == `IRA_BYTE_ADDR && fe_reg.rw) begin
                            fe_next.state = ST_TX;
                            fe_next.byte_idx = `IRA_BYTE_ADDR;
                            fe_next.shift = rd_data[15:8];
                            fe_next.sda_oe = !rd_data[15];
                        end else begin
                            fe_next.state = ST_RX;
                            fe_next.byte_idx = fe_reg.byte_idx + 3'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        fe_next.bit_cnt = fe_reg.bit_cnt + 4'h1;
                        if (fe_reg.bit_cnt == `IRA_BIT_LAST) begin
                            fe_next.sda_oe = 1'b0;
                            fe_next.state = ST_TX_ACK;
                        end else begin
                            fe_next.shift = {fe_reg.shift[6:0], 1'b0};
                            fe_next.sda_oe = !fe_reg.shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        fe_next.host_ack = !fe_reg.sda_s2;
                    end
                    if (scl_fall) begin
                        fe_next.bit_cnt = 4'h0;
                        if (fe_reg.host_ack && fe_reg.byte_idx == `IRA_BYTE_ADDR) begin
                            fe_next.state = ST_TX;
                            fe_next.byte_idx = `IRA_BYTE_CMD;
                            fe_next.shift = rd_data[7:0];
                            fe_next.sda_oe = !rd_data[7];
                        end else begin
                            fe_next.state = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: fe_next.sda_oe = 1'b0;
                ST_IDLE: fe_next.sda_oe = 1'b0;
                default: fe_next.state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fe_reg <= '0;
            fe_reg.state <= ST_IDLE;
            fe_reg.scl_s1 <= 1'b1;
            fe_reg.scl_s2 <= 1'b1;
            fe_reg.scl_p <= 1'b1;
            fe_reg.sda_s1 <= 1'b1;
            fe_reg.sda_s2 <= 1'b1;
            fe_reg.sda_p <= 1'b1;
        end else begin
            fe_reg <= fe_next;
        end
    end

    // ****************************************
    // Write buffer toward the register file
    // ****************************************
    ira_pair_buf #(.W(24)) u_wbuf (
        .clock(clock),
        .rst(rst),
        .in_valid(fe_reg.push),
        .in_ready(buf_in_ready),
        .in_data({fe_reg.cmd, fe_reg.upper, fe_reg.shift}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(buf_out)
    );

    assign wr_addr = buf_out[23:16];
    assign wr_data = buf_out[15:0];
    assign sda_out = 1'b0;
    assign sda_oe = fe_reg.sda_oe;
    assign rd_addr = fe_reg.rd_addr;
    assign soft_reset = fe_reg.swrst;

    // ****************************************
    // Checks
    // ****************************************
    ack_hold_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_RX_ACK && scl_rise |-> fe_reg.sda_oe)
        else $error("ack not held through clock high");
    update_len_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.push |-> fe_reg.rises == `IRA_UPDATE_RISES)
        else $error("update not 36 clock rises");
    both_bytes_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.push |-> fe_reg.byte_idx == `IRA_BYTE_LOWER && !fe_reg.gcall)
        else $error("commit before lower byte");
    commit_edge_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.push |-> $past(scl_fall) && $past(fe_reg.state) == ST_RX_ACK)
        else $error("commit not on ack falling edge");
    stop_release_a: assert property (@(posedge clock) disable iff (rst)
        stop_cond |=> fe_reg.state == ST_IDLE && !fe_reg.sda_oe)
        else $error("bus held after stop");
    read_match_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_TX |-> fe_reg.adr[6:3] == `IRA_ADDR_HI && fe_reg.rw)
        else $error("read served for foreign or broadcast address");
    strap_gnd_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_RX && fe_reg.byte_idx == `IRA_BYTE_CMD && !fe_reg.st_hi
        |-> fe_reg.strap_code == `IRA_STRAP_GND)
        else $error("grounded strap not decoded as zero");
    swrst_cause_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.swrst |-> fe_reg.gcall && fe_reg.shift == `IRA_SWRST_BYTE
        ##1 !fe_reg.swrst)
        else $error("soft reset without general call");
    strap_scl_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_RX_ACK && fe_reg.byte_idx == `IRA_BYTE_ADDR
        && fe_reg.strap_code == `IRA_STRAP_SCL |-> !fe_reg.st_nscl)
        else $error("clock strap decoded from a pin that left the clock");
    ack_match_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_RX_ACK && fe_reg.byte_idx == `IRA_BYTE_ADDR && !fe_reg.gcall
        |-> fe_reg.adr == {`IRA_ADDR_HI, fe_reg.strap_code} || fe_reg.adr == `IRA_BCAST_ADDR)
        else $error("address acknowledged without a match");
    wait_release_a: assert property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_WAIT || fe_reg.state == ST_TX_ACK |-> !fe_reg.sda_oe)
        else $error("data line held while waiting for stop");

    // ****************************************
    // Coverage
    // ****************************************
    write_cover_c: cover property (@(posedge clock) disable iff (rst) fe_reg.push);
    read_cover_c: cover property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_TX && fe_reg.byte_idx == `IRA_BYTE_CMD);
    swrst_cover_c: cover property (@(posedge clock) disable iff (rst) fe_reg.swrst);
    bcast_cover_c: cover property (@(posedge clock) disable iff (rst)
        fe_reg.push && fe_reg.adr == `IRA_BCAST_ADDR);
    comb_read_c: cover property (@(posedge clock) disable iff (rst)
        fe_reg.state == ST_TX && fe_reg.cmd_valid);
endmodule : ira_frontend

// *** dv/ira_bus_ctl.sv ***
// Bus controller model that drives the serial clock and pulls the data line
`timescale 1ns/100ps
module ira_bus_ctl (
    input wire logic clock,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end

    task automatic q;
        repeat (10) @(negedge clock);
    endtask : q

    // Data moves only while the clock is low, sampled mid-high
    task automatic bit_cyc(input logic v, output logic s);
        sda_low = !v;
        q;
        scl = 1'h1;
        q;
        s = sda_bus;
        q;
        scl = 1'h0;
        q;
    endtask : bit_cyc

    // Also serves as repeated start after an acknowledge
    task automatic start_c;
        sda_low = 1'h0;
        q;
        scl = 1'h1;
        q;
        sda_low = 1'h1;
        q;
        scl = 1'h0;
        q;
    endtask : start_c

    task automatic stop_c;
        sda_low = 1'h1;
        q;
        scl = 1'h1;
        q;
        sda_low = 1'h0;
        q;
    endtask : stop_c

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(b[i], s);
        end
        bit_cyc(1'h1, s);
        ack = !s;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'h1, s);
            b[i] = s;
        end
        bit_cyc(!ack, s);
    endtask : recv_byte
endmodule : ira_bus_ctl

// *** dv/tb.sv ***
// Self-checking testbench of the serial register access front end
`timescale 1ns/100ps
`define CHK(a, e) \
    begin \
        checks_done++; \
        if ((a) !== (e)) begin \
            n_mismatch++; \
            $display("CHECK FAILED %0t got %h want %h", $time, (a), (e)); \
        end \
    end
module tb import ira_pkg::*;;
    typedef struct {
        logic [1:0] strap;
        logic [6:0] addr;
        logic [7:0] cmd;
        logic [15:0] data;
        logic ack_a;
        logic ack_c;
        logic ack_d;
    } ira_row_s;
    logic clock;
    logic rst;
    logic wr_ready;
    logic [1:0] strap_sel;
    logic strap, scl, sda_low, sda_bus, sda_out, sda_oe;
    logic wr_valid, soft_reset, fall_valid;
    logic [7:0] wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data;
    logic [15:0] reg_mem [256];
    int n_mismatch, checks_done, rises, sr_cnt;
    ira_row_s rows [13] = '{
        '{2'h0, 7'h48, 8'hD0, 16'h1234, 1'h1, 1'h1, 1'h1},
        '{2'h1, 7'h49, 8'hD1, 16'hABCD, 1'h1, 1'h1, 1'h1},
        '{2'h2, 7'h4A, 8'hD3, 16'h00FF, 1'h1, 1'h1, 1'h1},
        '{2'h3, 7'h4B, 8'h21, 16'hFF00, 1'h1, 1'h1, 1'h1},
        '{2'h0, 7'h48, 8'h25, 16'h8001, 1'h1, 1'h1, 1'h1},
        '{2'h0, 7'h48, 8'h26, 16'h7FFE, 1'h1, 1'h1, 1'h1},
        '{2'h1, 7'h47, 8'h01, 16'h5AA5, 1'h1, 1'h1, 1'h1},
        '{2'h0, 7'h48, 8'h78, 16'h0F0F, 1'h1, 1'h1, 1'h1},
        '{2'h0, 7'h48, 8'h98, 16'hF0F0, 1'h1, 1'h1, 1'h1},
        '{2'h0, 7'h49, 8'h21, 16'h0000, 1'h0, 1'h0, 1'h0},
        '{2'h1, 7'h48, 8'h21, 16'h0000, 1'h0, 1'h0, 1'h0},
        '{2'h0, 7'h78, 8'h21, 16'h0000, 1'h0, 1'h0, 1'h0},
        '{2'h0, 7'h48, 8'h22, 16'h0000, 1'h1, 1'h0, 1'h0}
    };

    // ****************************************
    // Wiring and register file model
    // ****************************************
    assign sda_bus = !(sda_low || (sda_oe && !sda_out));
    assign strap = (strap_sel == 2'h0) ? 1'h0 : (strap_sel == 2'h1) ? 1'h1 :
                   (strap_sel == 2'h2) ? sda_bus : scl;
    assign rd_data = reg_mem[rd_addr];

    ira_frontend u_ira_frontend (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(strap),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .soft_reset(soft_reset));
    ira_bus_ctl u_ira_bus_ctl (.clock(clock), .sda_bus(sda_bus), .scl(scl),
        .sda_low(sda_low));

    always #2 clock = ~clock;
    always @(negedge scl) fall_valid = wr_valid;
    always @(posedge scl) rises++;
    always @(posedge clock) sr_cnt += (soft_reset === 1'h1);

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic sb(input logic [7:0] b, input logic e);
        logic a;
        u_ira_bus_ctl.send_byte(b, a);
        `CHK(a, e)
    endtask : sb

    task automatic rb(input logic ack, input logic [7:0] e);
        logic [7:0] b;
        u_ira_bus_ctl.recv_byte(ack, b);
        `CHK(b, e)
    endtask : rb

    task automatic take(input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (wr_valid !== 1'h1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        if (n == 40) begin
            n_mismatch++;
            $display("CHECK FAILED %0t no word offered", $time);
            end_of_test;
        end
        `CHK(wr_addr, a)
        `CHK(wr_data, d)
        reg_mem[a] = d;
        wr_ready = 1'h1;
        @(negedge clock);
        wr_ready = 1'h0;
    endtask : take

    // Hold leaves words in the buffer to fill it
    task automatic wr_frame(input ira_row_s r, input logic hold);
        u_ira_bus_ctl.start_c;
        rises = 0;
        sb({r.addr, 1'h0}, r.ack_a);
        if (r.ack_a) begin
            sb(r.cmd, r.ack_c);
        end
        if (r.ack_a && r.ack_c) begin
            sb(r.data[15:8], 1'h1);
            if (!hold) begin
                `CHK(wr_valid, 1'h0)
            end
            sb(r.data[7:0], r.ack_d);
            if (!hold) begin
                `CHK(rises, 36)
                `CHK(fall_valid, 1'h0)
                take(r.cmd, r.data);
            end
        end
        u_ira_bus_ctl.stop_c;
    endtask : wr_frame

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clock = 1'h0;
        rst = 1'h1;
        wr_ready = 1'h0;
        strap_sel = 2'h0;
        n_mismatch = 0;
        checks_done = 0;
        rises = 0;
        sr_cnt = 0;
        foreach (reg_mem[i]) reg_mem[i] = 16'h0000;
        repeat (5) @(negedge clock);
        `CHK(sda_oe, 1'h0)
        `CHK(wr_valid, 1'h0)
        `CHK(rd_addr, 8'h00)
        `CHK(soft_reset, 1'h0)
        rst = 1'h0;
        repeat (5) @(negedge clock);
        $display("test reset done");
        foreach (rows[i]) begin
            strap_sel = rows[i].strap;
            @(negedge clock);
            wr_frame(rows[i], 1'h0);
        end
        strap_sel = 2'h0;
        $display("test table done");
        u_ira_bus_ctl.start_c;
        sb(8'h90, 1'h1);
        sb(8'h21, 1'h1);
        sb(8'h11, 1'h1);
        u_ira_bus_ctl.stop_c;
        repeat (20) @(negedge clock);
        `CHK(wr_valid, 1'h0)
        wr_frame('{2'h0, 7'h48, 8'h21, 16'h1357, 1'h1, 1'h1, 1'h1}, 1'h0);
        u_ira_bus_ctl.start_c;
        sb(8'h91, 1'h1);
        rb(1'h1, 8'h13);
        rb(1'h0, 8'h57);
        u_ira_bus_ctl.stop_c;
        $display("test plain read done");
        u_ira_bus_ctl.start_c;
        sb(8'h90, 1'h1);
        sb(8'h25, 1'h1);
        u_ira_bus_ctl.start_c;
        sb(8'h91, 1'h1);
        rb(1'h1, 8'h80);
        rb(1'h0, 8'h01);
        u_ira_bus_ctl.stop_c;
        $display("test combined read done");
        u_ira_bus_ctl.start_c;
        sb(8'h8F, 1'h0);
        u_ira_bus_ctl.stop_c;
        u_ira_bus_ctl.start_c;
        sb(8'h90, 1'h1);
        sb(8'h26, 1'h1);
        sb(8'hAA, 1'h1);
        sb(8'h55, 1'h1);
        sb(8'h00, 1'h0);
        u_ira_bus_ctl.stop_c;
        take(8'h26, 16'hAA55);
        sb(8'h90, 1'h0);
        u_ira_bus_ctl.stop_c;
        $display("test refusals done");
        wr_frame('{2'h0, 7'h48, 8'h21, 16'h0001, 1'h1, 1'h1, 1'h1}, 1'h1);
        wr_frame('{2'h0, 7'h48, 8'h25, 16'h0002, 1'h1, 1'h1, 1'h1}, 1'h1);
        wr_frame('{2'h0, 7'h48, 8'h26, 16'h0003, 1'h1, 1'h1, 1'h0}, 1'h1);
        take(8'h21, 16'h0001);
        take(8'h25, 16'h0002);
        repeat (5) @(negedge clock);
        `CHK(wr_valid, 1'h0)
        $display("test buffer done");
        u_ira_bus_ctl.start_c;
        sb(8'h00, 1'h1);
        sb(8'h05, 1'h0);
        u_ira_bus_ctl.stop_c;
        `CHK(sr_cnt, 0)
        u_ira_bus_ctl.start_c;
        sb(8'h00, 1'h1);
        sb(8'h06, 1'h1);
        `CHK(sr_cnt, 1)
        u_ira_bus_ctl.stop_c;
        $display("test soft reset done");
        end_of_test;
    end
endmodule : tb
